/* design/fcvt_conv.sv */
// Purpose: combinational double to signed integer conversion
// Assumes: rounding mode already resolved by the caller
// Notes: any nan converts to the most negative integer
`timescale 1ns/10ps
module fcvt_conv import fcvt_pkg::*; (
    input wire logic [63:0] opnd_i,
    input wire logic [1:0] rmode_i,
    input wire logic word_i,
    output fcvt_res_t res_o
);

    logic sgn;
    logic [10:0] bexp;
    logic [51:0] frac;
    logic is_nan;
    logic [12:0] uexp;
    logic [127:0] fixed;
    logic [127:0] shifted;
    logic [63:0] ip;
    logic g;
    logic s;
    logic big;
    logic inc;
    logic [64:0] mag;
    logic [64:0] lim;
    logic ovf;
    logic inv;
    logic [63:0] sval;
    logic [63:0] smin;
    logic [63:0] smax;

    assign sgn = opnd_i[63];
    assign bexp = opnd_i[62:52];
    assign frac = opnd_i[51:0];
    assign is_nan = (&bexp) & (|frac);
    assign uexp = {2'b00, bexp} - FCVT_EXP_BIAS;
    // integer part in the top half, fraction in the bottom half
    assign fixed = {63'h0, |bexp, frac, 12'h000};
    assign shifted = fixed << uexp[5:0];

    always_comb begin
        ip = 64'h0;
        g = 1'b0;
        s = 1'b0;
        big = 1'b0;
        if (!uexp[12] && uexp[11:6] != 6'h00) begin
            big = 1'b1;
        end else if (!uexp[12]) begin
            ip = shifted[127:64];
            g = shifted[63];
            s = |shifted[62:0];
        end else if (uexp == 13'h1FFF) begin
            g = fixed[64];
            s = |fixed[63:0];
        end else begin
            s = (|bexp) | (|frac);
        end
    end

    always_comb begin
        case (rmode_i)
            FCVT_RC_NEAR: inc = g & (s | ip[0]);
            FCVT_RC_ZERO: inc = 1'b0;
            FCVT_RC_PINF: inc = !sgn & (g | s);
            FCVT_RC_NINF: inc = sgn & (g | s);
            default: inc = 1'b0;
        endcase
    end

    assign mag = {1'b0, ip} + {64'h0, inc};
    assign lim = word_i ? FCVT_LIM_W : FCVT_LIM_DW;
    // the negative side reaches one step further than the positive side
    assign ovf = big | (sgn ? (mag > lim) : (mag >= lim));
    assign inv = is_nan | ovf;
    assign sval = sgn ? (64'h0 - mag[63:0]) : mag[63:0];
    assign smin = word_i ? {32'h0, FCVT_W_MIN} : FCVT_DW_MIN;
    assign smax = word_i ? {32'h0, FCVT_W_MAX} : FCVT_DW_MAX;

    always_comb begin
        if (inv) begin
            res_o.value = (is_nan | sgn) ? smin : smax;
        end else if (word_i) begin
            res_o.value = {32'h0, sval[31:0]};
        end else begin
            res_o.value = sval;
        end
        res_o.fr = inc & !inv;
        res_o.fi = (g | s) & !inv;
        res_o.snan = is_nan & !frac[51];
        res_o.cvi = inv;
    end

endmodule // fcvt_conv

/* design/fcvt_pkg.sv */
// Purpose: shared constants and types of the float to integer convert unit
// Assumes: 64-bit double operands, 32-bit Wishbone register words
// Notes: bit positions count from the lsb of the register word
package fcvt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // instruction decode
    localparam logic [5:0] FCVT_OPC = 6'h3F;
    localparam logic [9:0] FCVT_XO_DW = 10'h32E;
    localparam logic [9:0] FCVT_XO_DWZ = 10'h32F;
    localparam logic [9:0] FCVT_XO_W = 10'h00E;

    ////////////////////////////////////////////////////////////////////////
    // rounding control encodings
    localparam logic [1:0] FCVT_RC_NEAR = 2'h0;
    localparam logic [1:0] FCVT_RC_ZERO = 2'h1;
    localparam logic [1:0] FCVT_RC_PINF = 2'h2;
    localparam logic [1:0] FCVT_RC_NINF = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // status and control register layout
    localparam int FCVT_B_XE = 2;
    localparam int FCVT_B_VE = 3;
    localparam int FCVT_B_FR = 4;
    localparam int FCVT_B_FI = 5;
    localparam int FCVT_B_XX = 6;
    localparam int FCVT_B_SNAN = 7;
    localparam int FCVT_B_CVI = 8;
    localparam int FCVT_B_OX = 9;
    localparam int FCVT_B_VX = 10;
    localparam int FCVT_B_FEX = 11;
    localparam int FCVT_B_FX = 12;
    localparam logic [31:0] FCVT_FP_STATUS_CONTROL_REG_RST = 32'h0000_0000;
    localparam logic [31:0] FCVT_FP_STATUS_CONTROL_REG_WMASK = 32'h0000_13FF;

    ////////////////////////////////////////////////////////////////////////
    // register offsets and interrupt bits
    localparam logic [7:0] FCVT_OFS_FP_STATUS_CONTROL_REG = 8'h00;
    localparam logic [7:0] FCVT_OFS_IRQ_STS = 8'h04;
    localparam logic [7:0] FCVT_OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] FCVT_OFS_LAST = 8'h0C;
    localparam int FCVT_IRQ_W = 4;
    localparam int FCVT_IRQ_DONE = 0;
    localparam int FCVT_IRQ_INV = 1;
    localparam int FCVT_IRQ_INX = 2;
    localparam int FCVT_IRQ_ILL = 3;
    localparam logic [3:0] FCVT_IRQ_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // numeric limits
    localparam logic [12:0] FCVT_EXP_BIAS = 13'h03FF;
    localparam logic [63:0] FCVT_DW_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] FCVT_DW_MIN = 64'h8000_0000_0000_0000;
    localparam logic [31:0] FCVT_W_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] FCVT_W_MIN = 32'h8000_0000;
    localparam logic [64:0] FCVT_LIM_DW = 65'h0_8000_0000_0000_0000;
    localparam logic [64:0] FCVT_LIM_W = 65'h0_0000_0000_8000_0000;

    typedef enum logic [1:0] {
        FCVT_OP_NONE,
        FCVT_OP_DW,
        FCVT_OP_DWZ,
        FCVT_OP_W
    } fcvt_op_t;

    typedef struct packed {
        logic [63:0] value;
        logic fr;
        logic fi;
        logic snan;
        logic cvi;
    } fcvt_res_t;

endpackage

/* design/fcvt_unit.sv */
// Purpose: float to integer convert unit with its status register
// Assumes: source operand arrives with the issue strobe, one cycle
// Notes: results, flags and condition field appear one cycle later
//
// Function
// - doubleword convert uses current rounding control
// - truncating doubleword convert rounds toward zero
// - doubleword out of range saturates
// - word convert uses current rounding control
// - word result in low word
// - word above range gives 7FFF FFFF
// - word below range gives 8000 0000
// - older word mnemonic behaves identically
// - doubleword sets fraction rounded on increment
// - doubleword sets fraction inexact when inexact
// - result class left alone after doubleword
// - doubleword flags updated; no record, field untouched
// - record form copies four summary bits
// - word forms always update status flags
// - word leaves class and codes undefined
// - doubleword illegal on 32-bit implementation
`timescale 1ns/10ps
module fcvt_unit import fcvt_pkg::*; #(
    parameter bit IMPL_64 = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic issue_i,
    input wire logic [31:0] instr_i,
    input wire logic [63:0] src_data_i,
    output logic tgt_we_o,
    output logic [4:0] tgt_idx_o,
    output logic [63:0] tgt_data_o,
    output logic cr1_we_o,
    output logic [3:0] cr1_o,
    output logic illegal_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic [9:0] xo;
    logic rec;
    logic opc_hit;
    fcvt_op_t op;
    logic is_dw;
    logic ill_go;
    logic go;
    logic [1:0] rmode;
    logic [31:0] fp_status_control_reg_ff;
    fcvt_res_t cres;

    assign xo = instr_i[10:1];
    assign rec = instr_i[0];
    assign opc_hit = instr_i[31:26] == FCVT_OPC;
    // both word mnemonics share one encoding, so one path serves them
    assign op = !opc_hit ? FCVT_OP_NONE :
                (xo == FCVT_XO_DW) ? FCVT_OP_DW :
                (xo == FCVT_XO_DWZ) ? FCVT_OP_DWZ :
                (xo == FCVT_XO_W) ? FCVT_OP_W : FCVT_OP_NONE;
    assign is_dw = (op == FCVT_OP_DW) || (op == FCVT_OP_DWZ);
    assign ill_go = issue_i & is_dw & !IMPL_64;
    assign go = issue_i & (op != FCVT_OP_NONE) & !ill_go;
    // truncating form ignores the rounding control field
    assign rmode = (op == FCVT_OP_DWZ) ? FCVT_RC_ZERO :
                   fp_status_control_reg_ff[1:0];

    fcvt_conv u_conv (
        .opnd_i(src_data_i),
        .rmode_i(rmode),
        .word_i(op == FCVT_OP_W),
        .res_o(cres)
    );

    ////////////////////////////////////////////////////////////////////////
    // register bus decode

    logic bus_go;
    logic wr_go;
    logic rd_go;
    logic hit_fp_status_control_reg;
    logic hit_sts;
    logic hit_mask;
    logic hit_last;
    logic [31:0] bmask;
    logic [31:0] wmask;
    logic ack_ff;

    // the access completes one edge before ack is seen
    assign bus_go = wb_cyc_i & wb_stb_i & !ack_ff;
    assign wr_go = bus_go & wb_we_i;
    assign rd_go = bus_go & !wb_we_i;
    assign hit_fp_status_control_reg = wb_adr_i == FCVT_OFS_FP_STATUS_CONTROL_REG;
    assign hit_sts = wb_adr_i == FCVT_OFS_IRQ_STS;
    assign hit_mask = wb_adr_i == FCVT_OFS_IRQ_MASK;
    assign hit_last = wb_adr_i == FCVT_OFS_LAST;

    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign bmask[8*i+7:8*i] = {8{wb_sel_i[i]}};
    end

    assign wmask = bmask & FCVT_FP_STATUS_CONTROL_REG_WMASK;

    ////////////////////////////////////////////////////////////////////////
    // status and control register update

    logic [31:0] sw_fp_status_control_reg;
    logic [31:0] nxt_fp_status_control_reg;
    logic nxt_vx;
    logic nxt_fex;
    logic hw_inv;
    logic sup_wr;
    logic cur_vx;
    logic cur_fex;
    logic [31:0] rd_fp_status_control_reg;

    assign sw_fp_status_control_reg = (wr_go & hit_fp_status_control_reg) ?
        ((fp_status_control_reg_ff & ~wmask) | (wb_dat_i & wmask)) : fp_status_control_reg_ff;
    assign hw_inv = cres.snan | cres.cvi;

    // conversion flags land on top of a same-cycle software write
    always_comb begin
        nxt_fp_status_control_reg = sw_fp_status_control_reg;
        if (go) begin
            nxt_fp_status_control_reg[FCVT_B_FR] = cres.fr;
            nxt_fp_status_control_reg[FCVT_B_FI] = cres.fi;
            nxt_fp_status_control_reg[FCVT_B_XX] = sw_fp_status_control_reg[FCVT_B_XX] | cres.fi;
            nxt_fp_status_control_reg[FCVT_B_SNAN] = sw_fp_status_control_reg[FCVT_B_SNAN] | cres.snan;
            nxt_fp_status_control_reg[FCVT_B_CVI] = sw_fp_status_control_reg[FCVT_B_CVI] | cres.cvi;
            nxt_fp_status_control_reg[FCVT_B_FX] = sw_fp_status_control_reg[FCVT_B_FX]
                | (cres.fi & !sw_fp_status_control_reg[FCVT_B_XX])
                | (cres.snan & !sw_fp_status_control_reg[FCVT_B_SNAN])
                | (cres.cvi & !sw_fp_status_control_reg[FCVT_B_CVI]);
        end
        nxt_fp_status_control_reg[FCVT_B_VX] = 1'b0;
        nxt_fp_status_control_reg[FCVT_B_FEX] = 1'b0;
    end

    assign nxt_vx = nxt_fp_status_control_reg[FCVT_B_SNAN] | nxt_fp_status_control_reg[FCVT_B_CVI];
    assign nxt_fex = (nxt_vx & nxt_fp_status_control_reg[FCVT_B_VE])
        | (nxt_fp_status_control_reg[FCVT_B_XX] & nxt_fp_status_control_reg[FCVT_B_XE]);
    assign cur_vx = fp_status_control_reg_ff[FCVT_B_SNAN] | fp_status_control_reg_ff[FCVT_B_CVI];
    assign cur_fex = (cur_vx & fp_status_control_reg_ff[FCVT_B_VE])
        | (fp_status_control_reg_ff[FCVT_B_XX] & fp_status_control_reg_ff[FCVT_B_XE]);
    // an enabled invalid operation leaves the target register alone
    assign sup_wr = hw_inv & sw_fp_status_control_reg[FCVT_B_VE];

    always_comb begin
        rd_fp_status_control_reg = fp_status_control_reg_ff;
        rd_fp_status_control_reg[FCVT_B_VX] = cur_vx;
        rd_fp_status_control_reg[FCVT_B_FEX] = cur_fex;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fp_status_control_reg_ff <= FCVT_FP_STATUS_CONTROL_REG_RST;
        end else begin
            fp_status_control_reg_ff <= nxt_fp_status_control_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    logic [3:0] sts_ff;
    logic [3:0] mask_ff;
    logic [3:0] ev;
    logic [3:0] nxt_sts;
    logic [3:0] nxt_mask;
    logic [31:0] last_ff;

    assign ev[FCVT_IRQ_DONE] = go;
    assign ev[FCVT_IRQ_INV] = go & hw_inv;
    assign ev[FCVT_IRQ_INX] = go & cres.fi;
    assign ev[FCVT_IRQ_ILL] = ill_go;
    // an event in the clearing cycle survives the read
    assign nxt_sts = ev | ((rd_go & hit_sts) ? FCVT_IRQ_RST : sts_ff);
    assign nxt_mask = (wr_go & hit_mask & wb_sel_i[0]) ?
        wb_dat_i[3:0] : mask_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts_ff <= FCVT_IRQ_RST;
            mask_ff <= FCVT_IRQ_RST;
            irq_o <= 1'b0;
        end else begin
            sts_ff <= nxt_sts;
            mask_ff <= nxt_mask;
            irq_o <= |(nxt_sts & nxt_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer

    logic [31:0] rdata;

    assign rdata = hit_fp_status_control_reg ? rd_fp_status_control_reg :
                   hit_sts ? {28'h0, sts_ff} :
                   hit_mask ? {28'h0, mask_ff} :
                   hit_last ? last_ff : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_go;
            if (rd_go) begin
                wb_dat_o <= rdata;
            end
        end
    end

    assign wb_ack_o = ack_ff;

    ////////////////////////////////////////////////////////////////////////
    // results toward the register file and condition field

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tgt_we_o <= 1'b0;
            tgt_idx_o <= 5'h00;
            tgt_data_o <= 64'h0;
            cr1_we_o <= 1'b0;
            cr1_o <= 4'h0;
            illegal_o <= 1'b0;
            last_ff <= 32'h0000_0000;
        end else begin
            // low word carries the word result, upper word reads zero
            tgt_we_o <= go & !sup_wr;
            tgt_idx_o <= instr_i[25:21];
            tgt_data_o <= cres.value;
            cr1_we_o <= go & rec;
            cr1_o <= {nxt_fp_status_control_reg[FCVT_B_FX], nxt_fex, nxt_vx,
                      nxt_fp_status_control_reg[FCVT_B_OX]};
            illegal_o <= ill_go;
            if (go) begin
                last_ff <= cres.value[31:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // the class field and the four condition codes are never written, so
    // after either conversion they simply keep their old value

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_dw_sat_pos: assert property (
        go && is_dw && !fp_status_control_reg_ff[FCVT_B_VE]
        && src_data_i == 64'h43E0_0000_0000_0000
        |=> tgt_we_o && tgt_data_o == FCVT_DW_MAX)
        else $error("doubleword positive saturation wrong");

    chk_dw_sat_neg: assert property (
        go && is_dw && !fp_status_control_reg_ff[FCVT_B_VE]
        && src_data_i == 64'hC3F0_0000_0000_0000
        |=> tgt_data_o == FCVT_DW_MIN && fp_status_control_reg_ff[FCVT_B_CVI])
        else $error("doubleword negative saturation wrong");

    chk_word_sat_hi: assert property (
        go && op == FCVT_OP_W && src_data_i == 64'h41E0_0000_0000_0000
        |=> tgt_data_o[31:0] == FCVT_W_MAX)
        else $error("word high saturation wrong");

    chk_word_sat_lo: assert property (
        go && op == FCVT_OP_W && src_data_i == 64'hC1F0_0000_0000_0000
        |=> tgt_data_o[31:0] == FCVT_W_MIN)
        else $error("word low saturation wrong");

    chk_trunc_half: assert property (
        go && op == FCVT_OP_DWZ && src_data_i == 64'h4004_0000_0000_0000
        |=> tgt_data_o == 64'h2 && !fp_status_control_reg_ff[FCVT_B_FR]
        && fp_status_control_reg_ff[FCVT_B_FI])
        else $error("truncating conversion wrong");

    chk_near_half: assert property (
        go && op == FCVT_OP_DW && fp_status_control_reg_ff[1:0] == FCVT_RC_NEAR
        && src_data_i == 64'h4004_0000_0000_0000
        |=> tgt_data_o == 64'h2 && !fp_status_control_reg_ff[FCVT_B_FR]
        && fp_status_control_reg_ff[FCVT_B_FI])
        else $error("nearest rounding wrong");

    chk_word_round: assert property (
        go && op == FCVT_OP_W && fp_status_control_reg_ff[1:0] == FCVT_RC_PINF
        && src_data_i == 64'h4004_0000_0000_0000
        |=> tgt_data_o == 64'h3)
        else $error("word rounding wrong");

    chk_cr1_copy: assert property (
        cr1_we_o |-> cr1_o == {fp_status_control_reg_ff[FCVT_B_FX], cur_fex, cur_vx,
                               fp_status_control_reg_ff[FCVT_B_OX]})
        else $error("condition field copy wrong");

    chk_cr1_quiet: assert property (
        issue_i && !rec |=> !cr1_we_o)
        else $error("condition field written without record");

    chk_illegal_dw: assert property (
        issue_i && is_dw |=> illegal_o == !IMPL_64
        && (tgt_we_o || !IMPL_64 || $past(sup_wr)))
        else $error("illegal instruction handling wrong");

    chk_irq_level: assert property (
        irq_o == |(sts_ff & mask_ff))
        else $error("interrupt level disagrees with status");

endmodule // fcvt_unit

/* testbench/fcvt_fpr_model.sv */
// Purpose: register file model standing in front of the convert unit
// Assumes: one source read and one result write per cycle
// Notes: source read is combinational off the source index field
`timescale 1ns/10ps
module fcvt_fpr_model (
    input wire logic clk_i,
    input wire logic ld_we_i,
    input wire logic [4:0] ld_idx_i,
    input wire logic [63:0] ld_data_i,
    input wire logic [4:0] rd_idx_i,
    output logic [63:0] rd_data_o,
    input wire logic wr_we_i,
    input wire logic [4:0] wr_idx_i,
    input wire logic [63:0] wr_data_i
);
    logic [63:0] fpr_ff [32];
    assign rd_data_o = fpr_ff[rd_idx_i];
    // bench preload wins; it never overlaps a result write
    always_ff @(posedge clk_i) begin
        if (ld_we_i) fpr_ff[ld_idx_i] <= ld_data_i;
        else if (wr_we_i) fpr_ff[wr_idx_i] <= wr_data_i;
    end
endmodule // fcvt_fpr_model

/* testbench/fcvt_unit_tb.sv */
// Purpose: self-checking bench of the float to integer convert unit
// Assumes: one-cycle result latency, one-cycle bus answer
// Notes: second instance without doubleword support checks illegal path
`timescale 1ns/10ps
module fcvt_unit_tb import fcvt_pkg::*; ;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic issue_i = 1'h0;
    logic ld_we = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] instr_i = 32'h0;
    logic [4:0] ld_idx = 5'h00;
    logic [63:0] ld_data = 64'h0;
    logic [63:0] src_data_i, tgt_data_o, mr;
    logic [63:0] rv [8];
    logic [31:0] wb_dat_o, r;
    logic [31:0] rng = 32'h716B;
    logic [3:0] cr1_o;
    logic [4:0] tgt_idx_o;
    logic wb_ack_o, tgt_we_o, cr1_we_o, illegal_o, irq_o, tgt_we2, illegal2;
    logic [9:0] xos [3] = '{FCVT_XO_DW, FCVT_XO_DWZ, FCVT_XO_W};
    int fails = 0;
    int total_checks = 0;
    typedef struct packed {
        logic [63:0] val;
        logic [63:0] msk;
        logic crwe;
        logic [3:0] cr;
        logic [4:0] idx;
    } fcvt_exp_t;
    fcvt_exp_t res_q [$];
    fcvt_exp_t me;
    logic [63:0] rd_q [$];

    always #2 clk_i = ~clk_i;

    fcvt_unit #(.IMPL_64(1'h1)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .issue_i(issue_i),
        .instr_i(instr_i), .src_data_i(src_data_i), .tgt_we_o(tgt_we_o),
        .tgt_idx_o(tgt_idx_o), .tgt_data_o(tgt_data_o),
        .cr1_we_o(cr1_we_o), .cr1_o(cr1_o), .illegal_o(illegal_o),
        .irq_o(irq_o));
    // narrow implementation shares every input with the main one
    fcvt_unit #(.IMPL_64(1'h0)) dut2 (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(), .wb_ack_o(), .issue_i(issue_i), .instr_i(instr_i),
        .src_data_i(src_data_i), .tgt_we_o(tgt_we2), .tgt_idx_o(),
        .tgt_data_o(), .cr1_we_o(), .cr1_o(), .illegal_o(illegal2),
        .irq_o());
    fcvt_fpr_model fpr (.clk_i(clk_i), .ld_we_i(ld_we), .ld_idx_i(ld_idx),
        .ld_data_i(ld_data), .rd_idx_i(instr_i[15:11]),
        .rd_data_o(src_data_i), .wr_we_i(tgt_we_o), .wr_idx_i(tgt_idx_o),
        .wr_data_i(tgt_data_o));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] e, g, m);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e & m, g & m);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [63:0] rmask(input logic w);
        return w ? 64'h0000_0000_FFFF_FFFF : 64'hFFFF_FFFF_FFFF_FFFF;
    endfunction

    // m is the compare mask of a read; writes push nothing
    task automatic bus(input logic we, input logic [7:0] a,
            input logic [31:0] d, input logic [31:0] m);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        if (!we) rd_q.push_back({m, d});
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (n >= 20) chk("wb_ack_o", 64'h1, 64'h0, 64'h1);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask

    task automatic issue(input logic [31:0] ins, input logic [63:0] s,
            input logic ill, input logic vld);
        @(posedge clk_i);
        ld_we <= 1'h1;
        ld_idx <= ins[15:11];
        ld_data <= s;
        @(posedge clk_i);
        ld_we <= 1'h0;
        issue_i <= 1'h1;
        instr_i <= ins;
        @(posedge clk_i);
        issue_i <= 1'h0;
        #1;
        chk("illegal2", 64'(ill), 64'(illegal2), 64'h1);
        chk("tgt_we2", 64'(vld & ~ill), 64'(tgt_we2), 64'h1);
        chk("illegal_o", 64'h0, 64'(illegal_o), 64'h1);
    endtask

    // f holds {rounded, inexact, invalid conversion, record}
    task automatic run_cv(input logic [9:0] xo, input logic [1:0] rm,
            input real s, input logic [63:0] v, input logic [3:0] f);
        logic w;
        w = (xo == FCVT_XO_W);
        bus(1'h1, FCVT_OFS_FP_STATUS_CONTROL_REG, {30'h0, rm}, 32'h0);
        res_q.push_back({v, rmask(w), f[0], f[2] | f[1], 1'h0, f[1], 1'h0,
            5'h03});
        issue({FCVT_OPC, 5'h03, 5'h00, 5'h07, xo, f[0]}, $realtobits(s), ~w,
            1'h1);
        bus(1'h0, FCVT_OFS_FP_STATUS_CONTROL_REG, {21'h0, f[1], 1'h0, f[1], 2'h0, f[2], f[3],
            2'h0, rm}, f[1] ? 32'h0503 : 32'h0533);
        bus(1'h0, FCVT_OFS_LAST, v[31:0], 32'hFFFF_FFFF);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (tgt_we_o === 1'h1 && res_q.size() == 0) begin
            fails++;
            $display("BAD tgt_we_o exp 0 got 1");
        end else if (tgt_we_o === 1'h1) begin
            me = res_q.pop_front();
            chk("tgt_data_o", me.val, tgt_data_o, me.msk);
            chk("cr1_we_o", 64'(me.crwe), 64'(cr1_we_o), 64'h1);
            chk("tgt_idx_o", 64'(me.idx), 64'(tgt_idx_o), 64'h1F);
            if (me.crwe) chk("cr1_o", 64'(me.cr), 64'(cr1_o), 64'hF);
        end
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && rd_q.size() > 0) begin
            mr = rd_q.pop_front();
            chk("wb_dat_o", 64'(mr[31:0]), 64'(wb_dat_o), 64'(mr[63:32]));
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("BAD watchdog exp finish got hang");
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        bus(1'h0, FCVT_OFS_FP_STATUS_CONTROL_REG, 32'h0, 32'hFFFF_FFFF);
        bus(1'h0, FCVT_OFS_IRQ_MASK, 32'h0, 32'hFFFF_FFFF);
        bus(1'h1, 8'h10, 32'hFFFF_FFFF, 32'h0);
        bus(1'h0, 8'h10, 32'h0, 32'hFFFF_FFFF);
        $display("end of reset and map test");
        run_cv(FCVT_XO_DW, 2'h0, 2.5, 64'h2, 4'h4);
        run_cv(FCVT_XO_DW, 2'h2, 2.5, 64'h3, 4'hD);
        run_cv(FCVT_XO_DWZ, 2'h2, 2.5, 64'h2, 4'h4);
        run_cv(FCVT_XO_DW, 2'h3, -2.5, 64'hFFFF_FFFF_FFFF_FFFD, 4'hD);
        run_cv(FCVT_XO_DW, 2'h1, 3.0, 64'h3, 4'h1);
        run_cv(FCVT_XO_DWZ, 2'h0, -(2.0 ** 63), FCVT_DW_MIN, 4'h0);
        run_cv(FCVT_XO_DWZ, 2'h0, 2.0 ** 63, FCVT_DW_MAX, 4'h3);
        run_cv(FCVT_XO_DW, 2'h0, -(2.0 ** 64), FCVT_DW_MIN, 4'h2);
        run_cv(FCVT_XO_W, 2'h0, 1.5, 64'h2, 4'hD);
        run_cv(FCVT_XO_W, 2'h1, 1.5, 64'h1, 4'h4);
        run_cv(FCVT_XO_W, 2'h2, 2.5, 64'h3, 4'hC);
        run_cv(FCVT_XO_W, 2'h3, -0.5, 64'hFFFF_FFFF, 4'hC);
        run_cv(FCVT_XO_W, 2'h0, 2.0 ** 31, 64'(FCVT_W_MAX), 4'h3);
        run_cv(FCVT_XO_W, 2'h2, -(2.0 ** 32), 64'(FCVT_W_MIN), 4'h2);
        issue({FCVT_OPC, 5'h04, 5'h00, 5'h07, 10'h00F, 1'h0}, 64'h0, 1'h0,
            1'h0);
        $display("end of conversion test");
        bus(1'h1, FCVT_OFS_FP_STATUS_CONTROL_REG, 32'h0, 32'h0);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            rv[i] = {{44{r[19]}}, r[19:0]};
            @(posedge clk_i);
            ld_we <= 1'h1;
            ld_idx <= 5'(i + 8);
            ld_data <= $realtobits($itor($signed(rv[i])));
        end
        // back to back issues, one per cycle
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            ld_we <= 1'h0;
            issue_i <= 1'h1;
            instr_i <= {FCVT_OPC, 5'(i + 16), 5'h00, 5'(i + 8), xos[i % 3],
                rv[i][0]};
            res_q.push_back({rv[i], rmask(i % 3 == 2), rv[i][0], 4'h0,
                5'(i + 16)});
        end
        @(posedge clk_i);
        issue_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        $display("end of burst test");
        bus(1'h0, FCVT_OFS_IRQ_STS, 32'h0, 32'h0);
        bus(1'h1, FCVT_OFS_IRQ_MASK, 32'h4, 32'h0);
        bus(1'h0, FCVT_OFS_IRQ_MASK, 32'h4, 32'hF);
        run_cv(FCVT_XO_DW, 2'h1, 3.0, 64'h3, 4'h0);
        chk("irq_o", 64'h0, 64'(irq_o), 64'h1);
        run_cv(FCVT_XO_DW, 2'h0, 2.5, 64'h2, 4'h4);
        chk("irq_o", 64'h1, 64'(irq_o), 64'h1);
        bus(1'h0, FCVT_OFS_IRQ_STS, 32'h5, 32'hF);
        @(posedge clk_i);
        #1;
        chk("irq_o", 64'h0, 64'(irq_o), 64'h1);
        chk("res_q", 64'h0, 64'(res_q.size()), 64'hFF);
        $display("end of interrupt test");
        stop_test();
    end
endmodule // fcvt_unit_tb
